// [jie_map.svh]
// Constant map of the jump, increment/decrement and interrupt-enable executor.
// Assumes byte addresses on an 8-bit AXI4-Lite address, one 32-bit word per register.
`ifndef JIE_MAP_SVH
`define JIE_MAP_SVH

// Register byte offsets
`define JIE_OFF_CTRL 8'h00
`define JIE_OFF_WORK 8'h04
`define JIE_OFF_STATUS 8'h08
`define JIE_OFF_FILE_ADDR 8'h0C
`define JIE_OFF_FILE_DATA 8'h10

// Control register fields
`define JIE_CTRL_IRQ_EN_BIT 0
`define JIE_CTRL_BRANCH_HI_LSB 8
`define JIE_CTRL_TABLE_HI_LSB 16

// Status register fields
`define JIE_STAT_PC_LSB 0
`define JIE_STAT_ZERO_BIT 16
`define JIE_STAT_BUBBLE_BIT 17

// Reset values
`define JIE_RST_IRQ_EN 1'b0
`define JIE_RST_BRANCH_HI 2'h0
`define JIE_RST_TABLE_HI 2'h0
`define JIE_RST_WORK 8'h00
`define JIE_RST_FILE 8'h00
`define JIE_RST_PC 10'h000
`define JIE_RST_FILE_ADDR 6'h00
`define JIE_RST_ZERO 1'b0
`define JIE_RST_BUBBLE 1'b0

// AXI responses
`define JIE_RESP_OKAY 2'h0
`define JIE_RESP_SLVERR 2'h2

// Instruction cycle counts
`define JIE_CYC_PLAIN 1
`define JIE_CYC_SKIP 2
`define JIE_CYC_JUMP 2

`endif

// [jie_pkg.sv]
// Types shared by the executor files.
// Assumes the fetch stage presents already decoded operations.
`default_nettype none

package jie_pkg;
  // Operations this block executes; anything else arrives as no-operation
  typedef enum logic [2:0] {
    OP_NOP,
    OP_DEC_SKIP_ZERO,
    OP_ADD_ONE,
    OP_INT_OFF,
    OP_INT_ON,
    OP_DIRECT_JUMP,
    OP_COMPUTED_JUMP
  } jie_op_t;
endpackage

`default_nettype wire

// [jie_regs_if.sv]
// Register access carrier between the AXI4-Lite slave and the executor core.
// Assumes one clock; all signals are sampled at its rising edge.
`timescale 1ns/1ns
`default_nettype none

interface jie_regs_if;
  logic wrEn; // Write accepted this cycle
  logic [7:0] wrAddr; // Write byte address
  logic [31:0] wrData; // Write data
  logic [3:0] wrStrb; // Write byte enables
  logic wrOk; // Write address is mapped
  logic [7:0] rdAddr; // Read byte address
  logic [31:0] rdData; // Read word for rdAddr
  logic rdOk; // Read address is mapped

  // Bus side issues accesses
  modport bus (output wrEn, output wrAddr, output wrData, output wrStrb, input wrOk,
               output rdAddr, input rdData, input rdOk);
  // Register side decodes and answers
  modport regs (input wrEn, input wrAddr, input wrData, input wrStrb, output wrOk,
                input rdAddr, output rdData, output rdOk);
endinterface

`default_nettype wire

// [jie_axil_slave.sv]
// AXI4-Lite slave front end for the executor registers.
// Assumes a single master, one write and one read outstanding at most.
`timescale 1ns/1ns
`default_nettype none
`include "jie_map.svh"

module jie_axil_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // Read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  jie_regs_if.bus regs
);

  logic wrFire; // Address and data both present, no response pending
  logic rdFire; // Read address accepted

  // Waiting for both channels lets the master send them in either order
  assign wrFire = awvalid && wvalid && !bvalid;
  assign awready = wrFire;
  assign wready = wrFire;
  assign rdFire = arvalid && !rvalid;
  assign arready = !rvalid;

  // Pass the accepted write straight to the register side
  assign regs.wrEn = wrFire;
  assign regs.wrAddr = awaddr;
  assign regs.wrData = wdata;
  assign regs.wrStrb = wstrb;
  assign regs.rdAddr = araddr;

  // Write response, held until bready
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp <= `JIE_RESP_OKAY;
    end
    else if (wrFire)
    begin
      bvalid <= 1'b1;
      bresp <= regs.wrOk ? `JIE_RESP_OKAY : `JIE_RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // Read data captured at acceptance, held until rready
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `JIE_RESP_OKAY;
    end
    else if (rdFire)
    begin
      rvalid <= 1'b1;
      rdata <= regs.rdOk ? regs.rdData : 32'h0000_0000;
      rresp <= regs.rdOk ? `JIE_RESP_OKAY : `JIE_RESP_SLVERR;
    end
    else if (rready)
    begin
      rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [jie_exec_core.sv]
// Executor for decrement-skip, increment, interrupt on/off and both jump forms.
// Assumes a fetch stage that fetches at pc with one cycle of latency; one clock = one instruction cycle.
// Overview of operation
// [RQ1] Decrement file register, result to working or file
// [RQ2] Zero decrement result discards prefetched instruction
// [RQ3] Decrement-skip takes one cycle, two when skipping
// [RQ4] Interrupts-off clears global enable in one cycle
// [RQ5] Interrupts-on sets global enable in one cycle
// [RQ6] Direct jump: immediate to pc low, buffer bit high
// [RQ7] Direct jump unconditional, flags kept, two cycles
// [RQ8] Increment file register, update zero, one cycle
// [RQ9] Computed jump: table pointer high, working register low
// [RQ10] Computed jump unconditional, flags kept, two cycles
// [RQ11] Decrement-skip leaves every status flag unchanged
// [RQ12] Jumps discard prefetched instruction, one bubble
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "jie_map.svh"

module jie_exec_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch stage
  input wire logic fetchValid,
  input wire jie_pkg::jie_op_t fetchOp,
  input wire logic [5:0] fetchFile,
  input wire logic fetchDest,
  input wire logic [8:0] fetchTarget,
  // Core state outputs
  output logic [9:0] pc,
  output logic discardFetch,
  output logic globalInterruptEnable,
  output logic zero,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  jie_regs_if regBus(); // Carrier to the bus front end

  logic [7:0] workingRegister; // Working register
  logic [1:0] branchHighBuffer; // High bit for the direct jump, taken from bit 1 only
  logic [1:0] tableHighPointer; // High bits for the computed jump
  logic [5:0] fileAddr; // Software window into the file registers
  logic [7:0] fileMem [64]; // File registers, flip-flops
  logic bubble; // Next presented instruction is thrown away
  logic execute; // A real instruction runs this cycle
  logic execDec;
  logic execAdd;
  logic execJump;
  logic [7:0] fileOperand; // Addressed file register
  logic [7:0] decResult;
  logic [7:0] addResult;
  logic [7:0] opResult; // Result of the arithmetic operation
  logic fileWrite; // Instruction writes a file register
  logic [31:0] ctrlWord;
  logic [31:0] next_ctrl;
  logic swCtrl;
  logic swWork;
  logic swFileAddr;
  logic swFileData;

  // Bus front end
  jie_axil_slave busSlave (
    .clk(clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regs(regBus)
  );

  // Merge new bytes under their strobes, keep the rest
  function automatic logic [31:0] laneMerge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Instruction qualification: a bubble slot never executes
  assign execute = fetchValid && !bubble;
  assign execDec = execute && (fetchOp == jie_pkg::OP_DEC_SKIP_ZERO);
  assign execAdd = execute && (fetchOp == jie_pkg::OP_ADD_ONE);
  assign execJump = execute && ((fetchOp == jie_pkg::OP_DIRECT_JUMP) || (fetchOp == jie_pkg::OP_COMPUTED_JUMP));
  assign discardFetch = bubble;

  // Arithmetic on the addressed file register
  assign fileOperand = fileMem[fetchFile];
  assign decResult = fileOperand - 8'h01; // RQ1
  assign addResult = fileOperand + 8'h01; // RQ8
  assign opResult = execDec ? decResult : addResult;
  assign fileWrite = (execDec || execAdd) && fetchDest;

  // Software register decode
  assign swCtrl = regBus.wrEn && (regBus.wrAddr == `JIE_OFF_CTRL);
  assign swWork = regBus.wrEn && (regBus.wrAddr == `JIE_OFF_WORK);
  assign swFileAddr = regBus.wrEn && (regBus.wrAddr == `JIE_OFF_FILE_ADDR);
  assign swFileData = regBus.wrEn && (regBus.wrAddr == `JIE_OFF_FILE_DATA);
  assign regBus.wrOk = (regBus.wrAddr == `JIE_OFF_CTRL) || (regBus.wrAddr == `JIE_OFF_WORK) ||
                       (regBus.wrAddr == `JIE_OFF_STATUS) || (regBus.wrAddr == `JIE_OFF_FILE_ADDR) ||
                       (regBus.wrAddr == `JIE_OFF_FILE_DATA);

  // Control word as software sees it
  always_comb
  begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[`JIE_CTRL_IRQ_EN_BIT] = globalInterruptEnable;
    ctrlWord[`JIE_CTRL_BRANCH_HI_LSB +: 2] = branchHighBuffer;
    ctrlWord[`JIE_CTRL_TABLE_HI_LSB +: 2] = tableHighPointer;
    next_ctrl = laneMerge(ctrlWord, regBus.wrData, regBus.wrStrb);
  end

  // Read mux; status shows live core state, unmapped reads answer an error
  always_comb
  begin
    regBus.rdData = 32'h0000_0000;
    regBus.rdOk = 1'b1;
    unique case (regBus.rdAddr)
      `JIE_OFF_CTRL: regBus.rdData = ctrlWord;
      `JIE_OFF_WORK: regBus.rdData[7:0] = workingRegister;
      `JIE_OFF_STATUS:
      begin
        regBus.rdData[`JIE_STAT_PC_LSB +: 10] = pc;
        regBus.rdData[`JIE_STAT_ZERO_BIT] = zero;
        regBus.rdData[`JIE_STAT_BUBBLE_BIT] = bubble;
      end
      `JIE_OFF_FILE_ADDR: regBus.rdData[5:0] = fileAddr;
      `JIE_OFF_FILE_DATA: regBus.rdData[7:0] = fileMem[fileAddr];
      default: regBus.rdOk = 1'b0;
    endcase
  end

  // Global interrupt enable; the instruction wins over a software write in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      globalInterruptEnable <= `JIE_RST_IRQ_EN;
    end
    else if (execute && (fetchOp == jie_pkg::OP_INT_OFF))
    begin
      globalInterruptEnable <= 1'b0; // RQ4
    end
    else if (execute && (fetchOp == jie_pkg::OP_INT_ON))
    begin
      globalInterruptEnable <= 1'b1; // RQ5
    end
    else if (swCtrl)
    begin
      globalInterruptEnable <= next_ctrl[`JIE_CTRL_IRQ_EN_BIT];
    end
  end

  // Jump high bits, written by software only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      branchHighBuffer <= `JIE_RST_BRANCH_HI;
      tableHighPointer <= `JIE_RST_TABLE_HI;
    end
    else if (swCtrl)
    begin
      branchHighBuffer <= next_ctrl[`JIE_CTRL_BRANCH_HI_LSB +: 2];
      tableHighPointer <= next_ctrl[`JIE_CTRL_TABLE_HI_LSB +: 2];
    end
  end

  // Working register: destination bit clear sends the result here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      workingRegister <= `JIE_RST_WORK;
    end
    else if ((execDec || execAdd) && !fetchDest)
    begin
      workingRegister <= opResult; // RQ1 RQ8
    end
    else if (swWork && regBus.wrStrb[0])
    begin
      workingRegister <= regBus.wrData[7:0];
    end
  end

  // Zero flag: only the increment touches it; decrement-skip and jumps leave it alone
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      zero <= `JIE_RST_ZERO;
    end
    else if (execAdd)
    begin
      zero <= (addResult == 8'h00); // RQ8 RQ11
    end
  end

  // Software file window address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fileAddr <= `JIE_RST_FILE_ADDR;
    end
    else if (swFileAddr && regBus.wrStrb[0])
    begin
      fileAddr <= regBus.wrData[5:0];
    end
  end

  // File registers; a software write loses against an instruction write in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 64; i++)
      begin
        fileMem[i] <= `JIE_RST_FILE;
      end
    end
    else if (fileWrite)
    begin
      fileMem[fetchFile] <= opResult; // RQ1 RQ8
    end
    else if (swFileData && regBus.wrStrb[0])
    begin
      fileMem[fileAddr] <= regBus.wrData[7:0];
    end
  end

  // Bubble: set by a zero decrement or a jump, spent by the next presented instruction
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bubble <= `JIE_RST_BUBBLE;
    end
    else if ((execDec && (decResult == 8'h00)) || execJump)
    begin
      bubble <= 1'b1; // RQ2 RQ3 RQ12
    end
    else if (fetchValid)
    begin
      bubble <= 1'b0;
    end
  end

  // Program counter: next fetch address; a jump reloads it, any consumed slot advances it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pc <= `JIE_RST_PC;
    end
    else if (execute && (fetchOp == jie_pkg::OP_DIRECT_JUMP))
    begin
      pc <= {branchHighBuffer[1], fetchTarget}; // RQ6 RQ7
    end
    else if (execute && (fetchOp == jie_pkg::OP_COMPUTED_JUMP))
    begin
      pc <= {tableHighPointer, workingRegister}; // RQ9 RQ10
    end
    else if (fetchValid)
    begin
      pc <= pc + 10'h001;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seqJumpIssued;
    execJump;
  endsequence

  sequence seqBubbleSpent;
    discardFetch ##1 !discardFetch;
  endsequence

  AST_DEC_TO_WORK: assert property (execDec && !fetchDest |=> workingRegister == $past(decResult)) // RQ1
    else $error("decrement result missing from working register");
  AST_DEC_TO_FILE: assert property (execDec && fetchDest |=> fileMem[$past(fetchFile)] == $past(decResult)) // RQ1
    else $error("decrement result missing from file register");
  AST_DEC_SKIP: assert property (execDec && decResult == 8'h00 ##1 fetchValid |-> seqBubbleSpent) // RQ2
    else $error("zero decrement did not discard exactly one instruction");
  AST_DEC_NO_SKIP: assert property (execDec && decResult != 8'h00 |=> !discardFetch) // RQ3
    else $error("nonzero decrement discarded an instruction");
  AST_INT_OFF: assert property (execute && fetchOp == jie_pkg::OP_INT_OFF |=> !globalInterruptEnable) // RQ4
    else $error("interrupts-off left enable set");
  AST_INT_ON: assert property (execute && fetchOp == jie_pkg::OP_INT_ON |=> globalInterruptEnable) // RQ5
    else $error("interrupts-on left enable clear");
  AST_DIRECT_TARGET: assert property (execute && fetchOp == jie_pkg::OP_DIRECT_JUMP |=>
                                      pc == {$past(branchHighBuffer[1]), $past(fetchTarget)}) // RQ6
    else $error("direct jump target wrong");
  AST_JUMP_FLAGS: assert property (seqJumpIssued |=> $stable(zero) && discardFetch) // RQ7 RQ10
    else $error("jump changed a flag or took one cycle");
  AST_ADD_ZERO: assert property (execAdd |=> zero == ($past(addResult) == 8'h00)) // RQ8
    else $error("increment zero flag wrong");
  AST_COMPUTED_TARGET: assert property (execute && fetchOp == jie_pkg::OP_COMPUTED_JUMP |=>
                                        pc == {$past(tableHighPointer), $past(workingRegister)}) // RQ9
    else $error("computed jump target wrong");
  AST_DEC_FLAGS: assert property (execDec |=> $stable(zero)) // RQ11
    else $error("decrement-skip changed zero flag");
  AST_JUMP_BUBBLE: assert property (seqJumpIssued ##1 fetchValid |-> seqBubbleSpent) // RQ12
    else $error("jump bubble not exactly one slot");

endmodule

`default_nettype wire

// [jie_exec_core_tb.sv]
// Self-checking bench for the jump, increment/decrement and interrupt-enable executor.
// Assumes the executor top alone, registers reached over AXI4-Lite at the offsets of jie_map.svh.
`timescale 1ns/1ns
`default_nettype none
`include "jie_map.svh"

module jie_exec_core_tb;
  // Clock, reset and fetch stimulus
  logic clk = 0, rst = 1, fetchValid = 0, fetchDest = 0;
  jie_pkg::jie_op_t fetchOp = jie_pkg::OP_NOP;
  logic [5:0] fetchFile = 6'h00;
  logic [8:0] fetchTarget = 9'h000;
  // AXI master side
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  // Design outputs
  logic [9:0] pc;
  logic discardFetch, globalInterruptEnable, zero, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // Reference model of the core state
  logic [7:0] mFile [64];
  logic [7:0] mWork = 8'h00, r;
  logic [9:0] mPc = 10'h000;
  logic [1:0] mBrHi = 2'h0, mTbHi = 2'h0;
  logic [5:0] mFa = 6'h00;
  logic mGie = 0, mZero = 0, mBub = 0;
  // Notes left by the drivers, oldest first
  logic [12:0] stepQ [$];
  logic [33:0] rdQ [$];
  logic [1:0] wrQ [$];
  logic [7:0] regList [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  int err_total = 0, checks = 0;
  integer seed = 47481;

  always #5 clk = ~clk;

  jie_exec_core u_dut (.clk(clk), .rst(rst), .fetchValid(fetchValid), .fetchOp(fetchOp),
    .fetchFile(fetchFile), .fetchDest(fetchDest), .fetchTarget(fetchTarget), .pc(pc),
    .discardFetch(discardFetch), .globalInterruptEnable(globalInterruptEnable), .zero(zero),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // Compare of core state after one presented slot, bubble or executed
  task automatic cmpStep(input logic [12:0] e, input logic [12:0] s);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH core state {pc,bubble,enable,zero} expected %h seen %h", e, s);
    end
  endtask

  // Compare of a bus answer, response code above the data word
  task automatic cmpBus(input string what, input logic [33:0] e, input logic [33:0] s);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask

  // Watcher: bus answers at their handshake edge, core state 1 ns after each edge with fetchValid high, bubble slots included
  always @(posedge clk)
  begin : watch
    logic stepSeen;
    stepSeen = fetchValid && !rst;
    if (bvalid && bready)
      cmpBus("bresp", {(wrQ.size() > 0) ? wrQ.pop_front() : 2'hx, 32'h0}, {bresp, 32'h0});
    if (rvalid && rready)
      cmpBus("rresp/rdata", (rdQ.size() > 0) ? rdQ.pop_front() : 34'hx, {rresp, rdata});
    #1;
    if (stepSeen)
      cmpStep((stepQ.size() > 0) ? stepQ.pop_front() : 13'hx,
              {pc, discardFetch, globalInterruptEnable, zero});
  end

  // Bounded wait for a handshake; running out ends the run
  // Selector 0 awready, 1 bvalid, 2 arready, 3 rvalid; read live at each edge, no reference passing
  task automatic waitHigh(input int which);
    int n;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if ((which == 0 && awready === 1'h1) || (which == 1 && bvalid === 1'h1) ||
          (which == 2 && arready === 1'h1) || (which == 3 && rvalid === 1'h1))
        break;
    end
    if (n == 100)
    begin
      err_total++;
      $display("MISMATCH handshake expected 1 seen 0");
      end_of_test();
    end
  endtask

  function automatic logic mapped(input logic [7:0] a);
    return a inside {`JIE_OFF_CTRL, `JIE_OFF_WORK, `JIE_OFF_STATUS, `JIE_OFF_FILE_ADDR, `JIE_OFF_FILE_DATA};
  endfunction

  // Register contents the model expects; reserved bits read as zero
  function automatic logic [31:0] expReg(input logic [7:0] a);
    case (a)
      `JIE_OFF_CTRL: return {14'h0, mTbHi, 6'h0, mBrHi, 7'h0, mGie};
      `JIE_OFF_WORK: return {24'h0, mWork};
      `JIE_OFF_STATUS: return {14'h0, mBub, mZero, 6'h0, mPc};
      `JIE_OFF_FILE_ADDR: return {26'h0, mFa};
      `JIE_OFF_FILE_DATA: return {24'h0, mFile[mFa]};
      default: return 32'h0;
    endcase
  endfunction

  // Write: address and data offered together, response taken before release
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    fetchValid <= 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    wrQ.push_back(mapped(a) ? `JIE_RESP_OKAY : `JIE_RESP_SLVERR);
    case (a)
      `JIE_OFF_CTRL:
      begin
        mGie = d[`JIE_CTRL_IRQ_EN_BIT];
        mBrHi = d[`JIE_CTRL_BRANCH_HI_LSB +: 2];
        mTbHi = d[`JIE_CTRL_TABLE_HI_LSB +: 2];
      end
      `JIE_OFF_WORK: mWork = d[7:0];
      `JIE_OFF_FILE_ADDR: mFa = d[5:0];
      `JIE_OFF_FILE_DATA: mFile[mFa] = d[7:0];
      default: ; // Status and unmapped words change nothing
    endcase
    waitHigh(0);
    awvalid <= 0;
    wvalid <= 0;
    waitHigh(1);
    bready <= 0;
  endtask

  // Read: the note is made from model state, which is frozen while fetch is idle
  task automatic axiRead(input logic [7:0] a);
    @(posedge clk);
    fetchValid <= 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    rdQ.push_back({mapped(a) ? `JIE_RESP_OKAY : `JIE_RESP_SLVERR, expReg(a)});
    waitHigh(2);
    arvalid <= 0;
    waitHigh(3);
    rready <= 0;
  endtask

  // Present one instruction and note the state expected one edge later
  task automatic exec(input jie_pkg::jie_op_t op, input logic [5:0] f, input logic d, input logic [8:0] t);
    @(posedge clk);
    fetchValid <= 1;
    fetchOp <= op;
    fetchFile <= f;
    fetchDest <= d;
    fetchTarget <= t;
    mPc = mPc + 10'h001;
    if (mBub)
      mBub = 0;
    else
      case (op)
        jie_pkg::OP_DEC_SKIP_ZERO:
        begin
          r = mFile[f] - 8'h01;
          if (d) mFile[f] = r; else mWork = r;
          mBub = (r == 8'h00);
        end
        jie_pkg::OP_ADD_ONE:
        begin
          r = mFile[f] + 8'h01;
          if (d) mFile[f] = r; else mWork = r;
          mZero = (r == 8'h00);
        end
        jie_pkg::OP_INT_OFF: mGie = 0;
        jie_pkg::OP_INT_ON: mGie = 1;
        jie_pkg::OP_DIRECT_JUMP:
        begin
          mPc = {mBrHi[1], t};
          mBub = 1;
        end
        jie_pkg::OP_COMPUTED_JUMP:
        begin
          mPc = {mTbHi, mWork};
          mBub = 1;
        end
        default: ;
      endcase
    stepQ.push_back({mPc, mBub, mGie, mZero});
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    // A note never matched by a result means the design went quiet somewhere
    if (stepQ.size() + rdQ.size() + wrQ.size() != 0)
    begin
      err_total++;
      $display("MISMATCH pending results expected 0 seen %0d", stepQ.size() + rdQ.size() + wrQ.size());
    end
    $display("Counts: %0d comparisons, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    foreach (mFile[i]) mFile[i] = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 0;
    // Reset values, a write to the read-only word, an unmapped word
    foreach (regList[i]) axiRead(regList[i]);
    axiWrite(`JIE_OFF_STATUS, 32'hFFFF_FFFF);
    axiWrite(8'h14, 32'h0000_0001);
    foreach (regList[i]) axiRead(regList[i]);
    // Preload every file register; 1 and 0xFF give zero results below
    for (int i = 0; i < 64; i++)
    begin
      axiWrite(`JIE_OFF_FILE_ADDR, 32'(i));
      axiWrite(`JIE_OFF_FILE_DATA, (i == 1) ? 32'h0000_0001 : (i == 2) ? 32'h0000_00FF : $random(seed));
    end
    $display("Register test done");
    // Skip on zero drops the next word; flags kept by the decrement
    exec(jie_pkg::OP_DEC_SKIP_ZERO, 6'h01, 1'h1, 9'h000);
    exec(jie_pkg::OP_INT_ON, 6'h00, 1'h0, 9'h000);
    exec(jie_pkg::OP_ADD_ONE, 6'h02, 1'h1, 9'h000);
    exec(jie_pkg::OP_DEC_SKIP_ZERO, 6'h03, 1'h0, 9'h000);
    exec(jie_pkg::OP_INT_ON, 6'h00, 1'h0, 9'h000);
    exec(jie_pkg::OP_INT_OFF, 6'h00, 1'h0, 9'h000);
    axiRead(`JIE_OFF_WORK);
    $display("Skip test done");
    // Direct jump with branch buffer 01 then 10; the word after it is dropped
    for (int k = 1; k < 3; k++)
    begin
      axiWrite(`JIE_OFF_CTRL, {14'h0, 2'h2, 6'h0, 2'(k), 7'h0, 1'h1});
      exec(jie_pkg::OP_DIRECT_JUMP, 6'h00, 1'h0, 9'($random(seed)));
      exec(jie_pkg::OP_INT_OFF, 6'h00, 1'h0, 9'h000);
      exec(jie_pkg::OP_NOP, 6'h00, 1'h0, 9'h000);
    end
    // Computed jump, then a jump in its bubble that must not take effect
    axiWrite(`JIE_OFF_WORK, 32'h0000_0034);
    exec(jie_pkg::OP_COMPUTED_JUMP, 6'h00, 1'h0, 9'h000);
    exec(jie_pkg::OP_DIRECT_JUMP, 6'h00, 1'h0, 9'h1FF);
    exec(jie_pkg::OP_NOP, 6'h00, 1'h0, 9'h000);
    axiRead(`JIE_OFF_STATUS);
    $display("Jump test done");
    // Random back-to-back stream, state read back now and then
    for (int k = 0; k < 600; k++)
    begin
      exec(jie_pkg::jie_op_t'(3'($unsigned($random(seed)) % 7)), 6'($random(seed)), 1'($random(seed)),
           9'($random(seed)));
      if (k % 32 == 31)
        axiRead(`JIE_OFF_STATUS);
    end
    // Final contents of every file register and the working register
    for (int i = 0; i < 64; i++)
    begin
      axiWrite(`JIE_OFF_FILE_ADDR, 32'(i));
      axiRead(`JIE_OFF_FILE_DATA);
    end
    axiRead(`JIE_OFF_WORK);
    axiRead(`JIE_OFF_CTRL);
    $display("Random test done");
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule

`default_nettype wire
